// ### flash_ctl_pkg.sv
// Constants and types shared by the flash page, protection and timing block
package flash_ctl_pkg;

  // ----------------------------------------------------------------
  // Register map and bus widths
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 12;
  localparam int MEM_ADDR_W = 16;
  localparam logic [11:0] CMD_ADDR = 12'hff8;
  localparam logic [11:0] PAGE_ADDR = 12'hff9;
  localparam logic [11:0] FREQH_ADDR = 12'hffa;
  localparam logic [11:0] FREQL_ADDR = 12'hffb;

  // ----------------------------------------------------------------
  // Commands, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
  localparam logic [7:0] CMD_ERASE = 8'h95;
  localparam logic [7:0] CMD_LOCK_SEL = 8'h5e;
  localparam int PAGE_COUNT = 128;
  localparam int PAGE_BYTES = 512;
  localparam int PAGE_W = 7;
  localparam int PAGE_LSB = 9;
  localparam int INFO_BIT = 7;
  localparam logic [15:0] INFO_BASE = 16'hfe00;
  localparam logic [7:0] ERASE_FILL = 8'hff;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET = 8'h00;
  localparam logic [1:0] STATUS_PAD = 2'h0;

  // ----------------------------------------------------------------
  // Timing base: a 10 us tick made from the kHz value
  // ----------------------------------------------------------------
  localparam int TICK_US = 10;
  localparam int HZ_PER_KHZ = 1000;
  localparam int US_PER_S = 1000000;
  localparam logic [16:0] TICK_STEP = 17'(US_PER_S / (TICK_US * HZ_PER_KHZ));
  localparam int PROG_TIME_US = 40;
  localparam int ERASE_TIME_US = 10000;
  localparam int CNT_W = 11;
  localparam logic [10:0] PROG_TICKS = 11'(PROG_TIME_US / TICK_US);
  localparam logic [10:0] ERASE_TICKS = 11'(ERASE_TIME_US / TICK_US);

  // Controller states, coded as the status value software reads
  typedef enum logic [5:0] {
    ST_LOCKED = 6'b000000,
    ST_FIRST = 6'b000001,
    ST_SECOND = 6'b000010,
    ST_UNLOCKED = 6'b000011,
    ST_LOCK_SEL = 6'b000100,
    ST_PROGRAM = 6'b001000,
    ST_ERASE = 6'b010000
  } ctl_state_t;

endpackage : flash_ctl_pkg

// ### flash_page_protect_timing.sv
// Flash page selection, sector write lock and program/erase timing base
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Any one of 128 pages is the single program and erase target.
// - Each page spans 512 bytes of flash.
// - Page erase fills every location of the selected page with FFh.
// - Page number is low 7 bits, compared with flash address 15:9.
// - Bit 7 set maps the information area at FE00h to FFFFh.
// - Page select and sector lock share one address; lock hides page.
// - Shared address reaches the sector lock only after command 5Eh.
// - Lock writes only set bits; zeros leave bits; register stays readable.
// - Set lock bit n refuses programming and erasing in sector n.
// - Frequency value is high byte over low byte, sixteen bits.
// - Program and erase durations are timed from the frequency value.
// - Unknown or out-of-order commands return the controller to locked; while programming or erasing, commands are ignored.
// - While unlocked only writes inside the selected page are programmed.
// - After unlock, command 95h starts erasing the selected page.
module flash_page_protect_timing #(
  parameter int SECTOR_PAGE_SHIFT = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [flash_ctl_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic memWr,
  input wire logic [flash_ctl_pkg::MEM_ADDR_W-1:0] memAddr,
  input wire logic [7:0] memData,
  output logic [flash_ctl_pkg::MEM_ADDR_W-1:0] flashAddr,
  output logic [7:0] flashData,
  output logic flashProgram,
  output logic flashErase,
  output logic flashInfoArea,
  output logic auxAreaMapEnable,
  output logic cpuHold,
  output logic accessRefused
);
  import flash_ctl_pkg::*;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // page span
  function automatic logic [PAGE_W-1:0] page_of(input logic [15:0] addr);
    page_of = addr[PAGE_LSB +: PAGE_W];
  endfunction : page_of

  function automatic logic sector_locked(input logic [7:0] bits, input logic [PAGE_W-1:0] pg);
    logic [PAGE_W-1:0] sect;
    sect = pg >> SECTOR_PAGE_SHIFT;
    sector_locked = bits[sect[2:0]];
  endfunction : sector_locked

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctl_state_t state_r, state_nxt;
  logic [7:0] pageSel_r, pageSel_nxt;
  logic [7:0] lock_r, lock_nxt;
  logic [7:0] freqHigh_r, freqHigh_nxt;
  logic [7:0] freqLow_r, freqLow_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [15:0] flashAddr_r, flashAddr_nxt;
  logic [7:0] flashData_r, flashData_nxt;
  logic flashInfo_r, flashInfo_nxt;
  logic refused_r, refused_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic [15:0] freqValue;
  logic [16:0] accSum;
  logic tick;
  logic busy;
  logic [PAGE_W-1:0] selPage;
  logic curLocked;

  assign freqValue = {freqHigh_r, freqLow_r};
  assign selPage = pageSel_r[PAGE_W-1:0];
  assign curLocked = sector_locked(lock_r, selPage);
  assign busy = (state_r == ST_PROGRAM) || (state_r == ST_ERASE);

  // tick every 10 us when value holds the clock in kHz
  assign accSum = {1'b0, acc_r} + TICK_STEP;
  assign tick = accSum >= {1'b0, freqValue};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Command sequencing, register writes, reads and operation timing
  always_comb begin
    state_nxt = state_r;
    pageSel_nxt = pageSel_r;
    lock_nxt = lock_r;
    freqHigh_nxt = freqHigh_r;
    freqLow_nxt = freqLow_r;
    acc_nxt = acc_r;
    cnt_nxt = cnt_r;
    flashAddr_nxt = flashAddr_r;
    flashData_nxt = flashData_r;
    flashInfo_nxt = flashInfo_r;
    refused_nxt = 1'b0;
    rdData_nxt = 8'h00;
    if (regWr) begin
      case (regAddr)
        CMD_ADDR: begin
          if (!busy) begin
            case (regWrData)
              CMD_UNLOCK1: begin
                state_nxt = (state_r == ST_LOCKED) ? ST_FIRST : ST_LOCKED;
              end
              CMD_UNLOCK2: begin
                state_nxt = (state_r == ST_FIRST) ? ST_SECOND : ST_LOCKED;
              end
              CMD_LOCK_SEL: begin
                state_nxt = ST_LOCK_SEL;
              end
              CMD_ERASE: begin
                if (state_r == ST_UNLOCKED && !curLocked) begin
                  state_nxt = ST_ERASE;
                  cnt_nxt = ERASE_TICKS;
                  acc_nxt = 16'h0000;
                  flashAddr_nxt = {selPage, {PAGE_LSB{1'b0}}};
                  flashData_nxt = ERASE_FILL;
                  flashInfo_nxt = pageSel_r[INFO_BIT] && (&selPage);
                end else begin
                  state_nxt = ST_LOCKED;
                  refused_nxt = (state_r == ST_UNLOCKED);
                end
              end
              default: begin
                state_nxt = ST_LOCKED;
              end
            endcase
          end
        end
        PAGE_ADDR: begin
          if (state_r == ST_LOCK_SEL) begin
            lock_nxt = lock_r | regWrData;
          end else if (state_r == ST_SECOND) begin
            state_nxt = (regWrData == pageSel_r) ? ST_UNLOCKED : ST_LOCKED;
          end else if (state_r == ST_LOCKED) begin
            pageSel_nxt = regWrData;
          end
        end
        FREQH_ADDR: begin
          freqHigh_nxt = regWrData;
        end
        FREQL_ADDR: begin
          freqLow_nxt = regWrData;
        end
        default: begin
        end
      endcase
    end
    // program only inside the open page
    if (memWr && state_r == ST_UNLOCKED) begin
      if (page_of(memAddr) == selPage && !curLocked) begin
        state_nxt = ST_PROGRAM;
        cnt_nxt = PROG_TICKS;
        acc_nxt = 16'h0000;
        flashAddr_nxt = memAddr;
        flashData_nxt = memData;
        flashInfo_nxt = pageSel_r[INFO_BIT] && (memAddr >= INFO_BASE);
      end else begin
        refused_nxt = 1'b1;
      end
    end
    if (busy) begin
      if (tick) begin
        acc_nxt = (freqValue == 16'h0000) ? 16'h0000 : 16'(accSum - {1'b0, freqValue});
        cnt_nxt = cnt_r - 11'h001;
        if (cnt_r == 11'h001) begin
          state_nxt = (state_r == ST_PROGRAM) ? ST_UNLOCKED : ST_LOCKED;
          flashInfo_nxt = 1'b0;
        end
      end else begin
        acc_nxt = accSum[15:0];
      end
    end
    if (regRd) begin
      case (regAddr)
        CMD_ADDR: rdData_nxt = {STATUS_PAD, state_r};
        PAGE_ADDR: rdData_nxt = (state_r == ST_LOCK_SEL) ? lock_r : pageSel_r;
        FREQH_ADDR: rdData_nxt = freqHigh_r;
        FREQL_ADDR: rdData_nxt = freqLow_r;
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // State update, frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_LOCKED;
      pageSel_r <= PAGE_RESET;
      lock_r <= LOCK_RESET;
      freqHigh_r <= FREQ_RESET;
      freqLow_r <= FREQ_RESET;
      acc_r <= 16'h0000;
      cnt_r <= 11'h000;
      flashAddr_r <= 16'h0000;
      flashData_r <= 8'h00;
      flashInfo_r <= 1'b0;
      refused_r <= 1'b0;
      rdData_r <= 8'h00;
    end else if (clkEn) begin
      state_r <= state_nxt;
      pageSel_r <= pageSel_nxt;
      lock_r <= lock_nxt;
      freqHigh_r <= freqHigh_nxt;
      freqLow_r <= freqLow_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      flashAddr_r <= flashAddr_nxt;
      flashData_r <= flashData_nxt;
      flashInfo_r <= flashInfo_nxt;
      refused_r <= refused_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // Outputs
  assign regRdData = rdData_r;
  assign flashAddr = flashAddr_r;
  assign flashData = flashData_r;
  assign flashProgram = (state_r == ST_PROGRAM);
  assign flashErase = (state_r == ST_ERASE);
  assign flashInfoArea = flashInfo_r;
  assign auxAreaMapEnable = pageSel_r[INFO_BIT];
  assign cpuHold = busy;
  assign accessRefused = refused_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence eraseCmd_s;
    clkEn && regWr && regAddr == CMD_ADDR && regWrData == CMD_ERASE;
  endsequence
  sequence eraseGo_s;
    eraseCmd_s ##0 (state_r == ST_UNLOCKED && !curLocked);
  endsequence

  lock_set_only_a: assert property (1 |=> (($past(lock_r) & ~lock_r) == 8'h00))
    else $error("sector lock bit cleared");
  lock_read_a: assert property (clkEn && regRd && regAddr == PAGE_ADDR
    && state_r == ST_LOCK_SEL |=> regRdData == $past(lock_r))
    else $error("lock register not read at shared address");
  page_hidden_a: assert property (clkEn && regWr && regAddr == PAGE_ADDR
    && state_r == ST_LOCK_SEL |=> $stable(pageSel_r))
    else $error("page select written while lock selected");
  erase_start_a: assert property (eraseGo_s |=> flashErase && cpuHold
    && flashAddr[15:9] == $past(selPage) && flashData == 8'hff)
    else $error("erase did not start on the open page");
  protect_refuse_a: assert property (clkEn && memWr && state_r == ST_UNLOCKED
    && curLocked |=> !flashProgram && accessRefused)
    else $error("program allowed in protected sector");
  outside_page_a: assert property (clkEn && memWr && state_r == ST_UNLOCKED
    && memAddr[15:9] != selPage |=> !flashProgram)
    else $error("write outside open page programmed");
  bad_cmd_lock_a: assert property (clkEn && regWr && regAddr == CMD_ADDR && !busy
    && regWrData != CMD_UNLOCK1 && regWrData != CMD_UNLOCK2 && regWrData != CMD_LOCK_SEL
    && !(regWrData == CMD_ERASE && state_r == ST_UNLOCKED && !curLocked)
    |=> state_r == ST_LOCKED)
    else $error("unknown command left controller open");
  freq_high_a: assert property (clkEn && regWr && regAddr == FREQH_ADDR
    |=> freqValue[15:8] == $past(regWrData))
    else $error("frequency high byte not placed in bits 15 to 8");
  info_map_a: assert property (clkEn && memWr && state_r == ST_UNLOCKED && !curLocked
    && memAddr[15:9] == selPage && pageSel_r[7] && memAddr >= 16'hfe00
    |=> flashProgram && flashInfoArea)
    else $error("information area not selected");
  prog_end_a: assert property (clkEn && state_r == ST_PROGRAM && tick && cnt_r == 11'h001
    |=> state_r == ST_UNLOCKED && !cpuHold)
    else $error("program did not end on its last tick");

endmodule : flash_page_protect_timing

`default_nettype wire

// ### flash_array_model.sv
// Behavioural flash array seen at the far side of the controller
`timescale 1ns/1ps
`default_nettype none

module flash_array_model (
  input wire logic ref_clk,
  input wire logic [15:0] flashAddr,
  input wire logic [7:0] flashData,
  input wire logic flashProgram,
  input wire logic flashErase
);
  logic [7:0] mem [logic [15:0]];
  logic progSeen = 1'b0;
  logic eraseSeen = 1'b0;

  // program on start, erase a whole 512 byte page to FFh
  always @(posedge ref_clk) begin
    if (flashProgram && !progSeen)
      mem[flashAddr] = flashData;
    if (flashErase && !eraseSeen) begin
      for (int i = 0; i < 512; i++)
        mem[{flashAddr[15:9], 9'(i)}] = 8'hff;
    end
    progSeen = flashProgram;
    eraseSeen = flashErase;
  end
endmodule : flash_array_model

`default_nettype wire

// ### test_flash_page_protect_timing.sv
// Register level test of the flash page, lock and timing block
`timescale 1ns/1ps
`default_nettype none

module test_flash_page_protect_timing;
  import flash_ctl_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic memWr = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] memData = 8'h00;
  logic [15:0] memAddr = 16'h0000;
  logic [7:0] regRdData, flashData;
  logic [15:0] flashAddr;
  logic flashProgram, flashErase, flashInfoArea, auxAreaMapEnable, cpuHold, accessRefused;
  int mismatches = 0;
  int n_tests = 0;
  int cyc;
  logic [7:0] badA [4] = '{8'h73, 8'h73, 8'h8c, 8'h73};
  logic [7:0] badB [4] = '{8'h73, 8'h00, 8'h8c, 8'h95};

  flash_page_protect_timing #(.SECTOR_PAGE_SHIFT(4)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .memWr(memWr), .memAddr(memAddr), .memData(memData), .flashAddr(flashAddr),
    .flashData(flashData), .flashProgram(flashProgram), .flashErase(flashErase),
    .flashInfoArea(flashInfoArea), .auxAreaMapEnable(auxAreaMapEnable),
    .cpuHold(cpuHold), .accessRefused(accessRefused));

  flash_array_model FM (.ref_clk(ref_clk), .flashAddr(flashAddr), .flashData(flashData),
    .flashProgram(flashProgram), .flashErase(flashErase));

  // ----------------------------------------------------------------
  // Clock, verdict and helpers
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(16'(regRdData), 16'(exp));
  endtask : rd

  // software unlock order with page written twice
  task automatic unlock(input logic [7:0] pg);
    wr(PAGE_ADDR, pg);
    wr(CMD_ADDR, CMD_UNLOCK1);
    wr(CMD_ADDR, CMD_UNLOCK2);
    wr(PAGE_ADDR, pg);
  endtask : unlock

  task automatic mwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    memWr <= 1'b1;
    memAddr <= a;
    memData <= d;
    @(posedge ref_clk);
    memWr <= 1'b0;
    #1;
  endtask : mwr

  task automatic hold_wait(output int n);
    n = 0;
    while (cpuHold === 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 20000) begin
      mismatches++;
      stop_test();
    end
  endtask : hold_wait

  initial begin
    #400000;
    mismatches++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(PAGE_ADDR, PAGE_RESET);
    rd(FREQH_ADDR, FREQ_RESET);
    rd(FREQL_ADDR, FREQ_RESET);
    rd(CMD_ADDR, 8'h00);
    rd(12'h100, 8'h00);
    // load 1000 kHz before any operation
    wr(FREQH_ADDR, 8'h03);
    wr(FREQL_ADDR, 8'he8);
    rd(FREQH_ADDR, 8'h03);
    rd(FREQL_ADDR, 8'he8);
    // Clock enable low freezes register writes
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(FREQH_ADDR, 8'h55);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    rd(FREQH_ADDR, 8'h03);
    // Command pairs out of order fall back to locked
    for (int i = 0; i < 4; i++) begin
      wr(CMD_ADDR, badA[i]);
      wr(CMD_ADDR, badB[i]);
      rd(CMD_ADDR, 8'h00);
    end
    wr(PAGE_ADDR, 8'h10);
    wr(CMD_ADDR, CMD_UNLOCK1);
    rd(CMD_ADDR, 8'h01);
    wr(CMD_ADDR, CMD_UNLOCK2);
    rd(CMD_ADDR, 8'h02);
    wr(PAGE_ADDR, 8'h11);
    rd(CMD_ADDR, 8'h00);
    // Info area page, program and erase
    FM.mem[16'hfc10] = 8'h3c;
    unlock(8'hff);
    rd(CMD_ADDR, 8'h03);
    chk(16'(auxAreaMapEnable), 16'h1);
    mwr(16'hfe10, 8'ha5);
    chk(16'(flashProgram), 16'h1);
    chk(flashAddr, 16'hfe10);
    chk(16'(flashData), 16'h00a5);
    chk(16'(flashInfoArea), 16'h1);
    hold_wait(cyc);
    chk(16'(cyc >= 30 && cyc <= 41), 16'h1);
    chk(16'(FM.mem[16'hfe10]), 16'h00a5);
    rd(CMD_ADDR, 8'h03);
    mwr(16'hfdff, 8'h11);
    chk(16'({accessRefused, flashProgram}), 16'h2);
    wr(CMD_ADDR, CMD_ERASE);
    #1 chk(16'(flashErase), 16'h1);
    chk(flashAddr, INFO_BASE);
    chk(16'(flashData), 16'(ERASE_FILL));
    chk(16'(flashInfoArea), 16'h1);
    hold_wait(cyc);
    chk(16'(cyc >= 9990 && cyc <= 10010), 16'h1);
    chk(16'(FM.mem[16'hfe10]), 16'h00ff);
    chk(16'(FM.mem[16'hfc10]), 16'h003c);
    rd(CMD_ADDR, 8'h00);
    wr(PAGE_ADDR, 8'h05);
    #1 chk(16'(auxAreaMapEnable), 16'h0);
    rd(PAGE_ADDR, 8'h05);
    // Sector lock behind command 5Eh, set only
    wr(CMD_ADDR, CMD_LOCK_SEL);
    rd(CMD_ADDR, 8'h04);
    rd(PAGE_ADDR, LOCK_RESET);
    wr(PAGE_ADDR, 8'h02);
    rd(PAGE_ADDR, 8'h02);
    wr(PAGE_ADDR, 8'h01);
    rd(PAGE_ADDR, 8'h03);
    wr(PAGE_ADDR, 8'h00);
    rd(PAGE_ADDR, 8'h03);
    wr(CMD_ADDR, 8'h00);
    rd(PAGE_ADDR, 8'h05);
    // Locked sector 1 refuses program and erase
    unlock(8'h10);
    mwr(16'h2000, 8'h77);
    chk(16'({accessRefused, flashProgram}), 16'h2);
    wr(CMD_ADDR, CMD_ERASE);
    #1 chk(16'({accessRefused, flashErase}), 16'h2);
    rd(CMD_ADDR, 8'h00);
    // doubled clock value doubles program time
    wr(FREQH_ADDR, 8'h07);
    wr(FREQL_ADDR, 8'hd0);
    // Free sector 2 still programs
    unlock(8'h20);
    mwr(16'h4000, 8'h5a);
    chk(16'(flashProgram), 16'h1);
    chk(16'(flashInfoArea), 16'h0);
    hold_wait(cyc);
    chk(16'(cyc >= 70 && cyc <= 81), 16'h1);
    chk(16'(FM.mem[16'h4000]), 16'h005a);
    stop_test();
  end
endmodule : test_flash_page_protect_timing

`default_nettype wire
